// file: core/codec_defines.svh
// Byte values, frame codes and mode codes of the serial API frame codec
// Assumes byte-wide UART receive and transmit logic on the same clock
// What this block does
// - Mode input 1 selects plain framing, 2 selects framing with byte escaping
// - Receiver discards every byte until a 0x7E start delimiter arrives
// - Malformed or bad-checksum frames make the device send an error status frame
// - Escaped mode: send 0x7D then byte XOR 0x20; receiver undoes this
// - Escaped mode escapes exactly 0x7E, 0x7D, 0x11 and 0x13, both directions
// - Whoever sends a frame escapes it; whoever receives it unescapes it
// - Without escaping, 0x11 and 0x13 pass through unchanged
// - Length is two bytes, MSB first, counting frame data without checksum
// - Length and checksum cover unescaped data; escape bytes count for neither
// - Sender checksum is 0xFF minus low 8 bits of frame-data sum
// - Receiver accepts only when frame data plus checksum sums to 0xFF
// - First frame-data byte is the frame type identifier
// - Multi-byte values inside frame data go most significant byte first
`ifndef CODEC_DEFINES_SVH
`define CODEC_DEFINES_SVH

`define MODE_PLAIN        2'h1
`define MODE_ESCAPED      2'h2

`define DELIM             8'h7E
`define ESC               8'h7D
`define XON               8'h11
`define XOFF              8'h13
`define ESC_XOR           8'h20
`define CKSUM_GOOD        8'hFF

`define STATUS_FRAME_TYPE 8'h8A
`define STATUS_LEN        16'h0002
`define ERR_MALFORMED     8'h01
`define ERR_CHECKSUM      8'h02
`define ERR_OVERRUN       8'h03

`endif

// file: core/codec_pkg.sv
// Types and byte classification for the serial API frame codec
// Assumes codec_defines.svh is on the include path
`include "codec_defines.svh"
package codec_pkg;
   typedef enum logic [2:0] {RX_HUNT, RX_LEN_HI, RX_LEN_LO, RX_DATA, RX_CKSUM} rx_state_type;
   typedef enum logic [2:0] {TX_IDLE, TX_DELIM, TX_LEN_HI, TX_LEN_LO, TX_STAT_TYPE, TX_STAT_CODE,
                             TX_DATA, TX_CKSUM} tx_state_type;

   function automatic logic needs_escape(input logic [7:0] b);
      return (b == `DELIM) || (b == `ESC) || (b == `XON) || (b == `XOFF);
   endfunction
endpackage

// file: core/frame_byte_escaper.sv
// Transmit byte escaper: splits a special byte into escape plus flipped byte
// Assumes one clock, synchronous active-high reset, sink with valid and ready
`timescale 1ns/1ns
`include "codec_defines.svh"
module frame_byte_escaper (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic [7:0] in_data,
   input  wire logic       in_escape,
   input  wire logic       in_valid,
   output logic            in_ready,
   output logic      [7:0] out_data,
   output logic            out_valid,
   input  wire logic       out_ready
);
   logic [7:0] out_data_reg;
   logic       out_valid_reg;
   logic       pend_reg;
   logic [7:0] pend_data_reg;

   wire slot_free = !out_valid_reg || out_ready;
   wire split     = in_escape && codec_pkg::needs_escape(in_data);

   assign in_ready  = slot_free && !pend_reg;
   assign out_data  = out_data_reg;
   assign out_valid = out_valid_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         out_data_reg  <= 8'h00;
         out_valid_reg <= 1'b0;
         pend_reg      <= 1'b0;
         pend_data_reg <= 8'h00;
      end else if (slot_free && pend_reg) begin
         out_data_reg  <= pend_data_reg ^ `ESC_XOR;
         out_valid_reg <= 1'b1;
         pend_reg      <= 1'b0;
      end else if (slot_free && in_valid) begin
         out_data_reg  <= split ? `ESC : in_data;
         out_valid_reg <= 1'b1;
         pend_reg      <= split;
         pend_data_reg <= in_data;
      end else if (slot_free) begin
         out_valid_reg <= 1'b0;
      end
   end
endmodule

// file: core/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides
// Assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module two_entry_buffer #(
   parameter int WIDTH = 9
) (
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   if (WIDTH < 1) begin : g_bad_width
      $error("two_entry_buffer needs WIDTH of at least 1");
   end

   logic [WIDTH-1:0] mem_reg [2];
   logic [1:0]       valid_reg;

   wire pop  = valid_reg[0] && out_ready;
   wire push = in_valid && !valid_reg[1];

   // Head always sits in entry 0 so the outputs come straight from flops
   assign out_data  = mem_reg[0];
   assign out_valid = valid_reg[0];
   assign in_ready  = !valid_reg[1];

   always_ff @(posedge clk) begin
      if (reset) begin
         valid_reg  <= 2'h0;
         mem_reg[0] <= '0;
         mem_reg[1] <= '0;
      end else if (pop) begin
         mem_reg[0]   <= valid_reg[1] ? mem_reg[1] : in_data;
         valid_reg[0] <= valid_reg[1] || push;
         valid_reg[1] <= 1'b0;
      end else if (push && valid_reg[0]) begin
         mem_reg[1]   <= in_data;
         valid_reg[1] <= 1'b1;
      end else if (push) begin
         mem_reg[0]   <= in_data;
         valid_reg[0] <= 1'b1;
      end
   end
endmodule

// file: core/uart_api_frame_codec.sv
// Serial API frame codec: deframes UART bytes, frames outgoing payloads
// Assumes UART byte logic on the same clock; the receive side cannot stall
`timescale 1ns/1ns
`include "codec_defines.svh"
module uart_api_frame_codec #(
   parameter int MAX_LEN = 65535
) (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic [1:0]  framing_mode_select,
   input  wire logic [7:0]  uart_rx_byte,
   input  wire logic        uart_rx_valid,
   output logic      [7:0]  uart_tx_byte,
   output logic             uart_tx_valid,
   input  wire logic        uart_tx_ready,
   output logic      [7:0]  rx_data,
   output logic             rx_last,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic             frame_good,
   output logic             frame_bad,
   output logic      [7:0]  err_code,
   input  wire logic        tx_start,
   input  wire logic [15:0] tx_len,
   input  wire logic [7:0]  tx_data,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   output logic             tx_busy
);
   if (MAX_LEN < 1 || MAX_LEN > 65535) begin : g_bad_max
      $error("MAX_LEN must lie between 1 and 65535");
   end

   localparam logic [15:0] MAX_LEN_W = 16'(MAX_LEN);

   // Receive side state
   codec_pkg::rx_state_type rx_state_reg, rx_state_next;
   logic [7:0]  rx_len_hi_reg, rx_len_hi_next;
   logic [15:0] rx_cnt_reg, rx_cnt_next;
   logic [7:0]  rx_sum_reg, rx_sum_next;
   logic        rx_esc_pend_reg, rx_esc_pend_next;
   logic        good_reg, good_next;
   logic        bad_reg, bad_next;
   logic [7:0]  err_code_reg, err_code_next;
   logic        err_pend_reg, err_pend_next;

   // Transmit side state
   codec_pkg::tx_state_type tx_state_reg, tx_state_next;
   logic [15:0] tx_len_reg, tx_len_next;
   logic [15:0] tx_cnt_reg, tx_cnt_next;
   logic [7:0]  tx_sum_reg, tx_sum_next;
   logic        tx_status_reg, tx_status_next;
   logic [7:0]  tx_code_reg, tx_code_next;
   logic        tx_ready_reg, tx_ready_next;
   logic        tx_busy_reg;
   logic [7:0]  esc_in_data_reg, esc_in_data_next;
   logic        esc_in_valid_reg, esc_in_valid_next;
   logic        esc_in_esc_reg, esc_in_esc_next;
   logic        load;
   logic [7:0]  load_data;
   logic        stat_taken;

   wire         esc_in_ready;
   wire         buf_in_ready;

   wire esc_mode = framing_mode_select == `MODE_ESCAPED;
   wire raw_delim = uart_rx_byte == `DELIM;
   // In escaped mode a bare delimiter can only start a frame
   wire rx_restart = uart_rx_valid && esc_mode && raw_delim;
   wire rx_esc_byte = uart_rx_valid && esc_mode && !rx_esc_pend_reg && uart_rx_byte == `ESC;
   wire [7:0] rx_d = rx_esc_pend_reg ? uart_rx_byte ^ `ESC_XOR : uart_rx_byte;
   wire rx_plain_byte = uart_rx_valid && !rx_restart && !rx_esc_byte;
   wire [7:0] rx_sum_d = rx_sum_reg + rx_d;
   wire [15:0] rx_len_w = {rx_len_hi_reg, rx_d};
   wire len_bad = rx_len_w == 16'h0000 || rx_len_w > MAX_LEN_W;
   wire buf_in_valid = rx_plain_byte && rx_state_reg == codec_pkg::RX_DATA;
   // A UART cannot be held off, so a full buffer aborts the frame instead
   wire overrun = buf_in_valid && !buf_in_ready;
   wire buf_push = buf_in_valid && buf_in_ready;
   wire rx_last_in = rx_cnt_reg == 16'h0001;

   always_comb begin
      rx_state_next    = rx_state_reg;
      rx_len_hi_next   = rx_len_hi_reg;
      rx_cnt_next      = rx_cnt_reg;
      rx_sum_next      = rx_sum_reg;
      rx_esc_pend_next = rx_esc_pend_reg;
      good_next        = 1'b0;
      bad_next         = 1'b0;
      err_code_next    = err_code_reg;
      if (rx_restart) begin
         if (rx_state_reg != codec_pkg::RX_HUNT) begin
            bad_next      = 1'b1;
            err_code_next = `ERR_MALFORMED;
         end
         rx_state_next    = codec_pkg::RX_LEN_HI;
         rx_esc_pend_next = 1'b0;
      end else if (rx_esc_byte) begin
         rx_esc_pend_next = 1'b1;
      end else if (rx_plain_byte) begin
         rx_esc_pend_next = 1'b0;
         unique case (rx_state_reg)
            codec_pkg::RX_HUNT: begin
               if (raw_delim) begin
                  rx_state_next = codec_pkg::RX_LEN_HI;
               end
            end
            codec_pkg::RX_LEN_HI: begin
               rx_len_hi_next = rx_d;
               rx_state_next  = codec_pkg::RX_LEN_LO;
            end
            codec_pkg::RX_LEN_LO: begin
               if (len_bad) begin
                  bad_next      = 1'b1;
                  err_code_next = `ERR_MALFORMED;
                  rx_state_next = codec_pkg::RX_HUNT;
               end else begin
                  rx_cnt_next   = rx_len_w;
                  rx_sum_next   = 8'h00;
                  rx_state_next = codec_pkg::RX_DATA;
               end
            end
            codec_pkg::RX_DATA: begin
               if (overrun) begin
                  bad_next      = 1'b1;
                  err_code_next = `ERR_OVERRUN;
                  rx_state_next = codec_pkg::RX_HUNT;
               end else begin
                  rx_sum_next = rx_sum_d;
                  rx_cnt_next = rx_cnt_reg - 16'h0001;
                  if (rx_last_in) begin
                     rx_state_next = codec_pkg::RX_CKSUM;
                  end
               end
            end
            codec_pkg::RX_CKSUM: begin
               if (rx_sum_d == `CKSUM_GOOD) begin
                  good_next = 1'b1;
               end else begin
                  bad_next      = 1'b1;
                  err_code_next = `ERR_CHECKSUM;
               end
               rx_state_next = codec_pkg::RX_HUNT;
            end
         endcase
      end
   end

   // Error raised while the last one is being taken still gets reported
   assign err_pend_next = bad_next || (err_pend_reg && !stat_taken);

   wire esc_slot = !esc_in_valid_reg || esc_in_ready;
   wire tx_take = tx_valid && tx_ready_reg;

   always_comb begin
      tx_state_next  = tx_state_reg;
      tx_len_next    = tx_len_reg;
      tx_cnt_next    = tx_cnt_reg;
      tx_sum_next    = tx_sum_reg;
      tx_status_next = tx_status_reg;
      tx_code_next   = tx_code_reg;
      stat_taken     = 1'b0;
      load           = 1'b0;
      load_data      = 8'h00;
      unique case (tx_state_reg)
         codec_pkg::TX_IDLE: begin
            if (err_pend_reg) begin
               stat_taken     = 1'b1;
               tx_status_next = 1'b1;
               tx_code_next   = err_code_reg;
               tx_len_next    = `STATUS_LEN;
               tx_state_next  = codec_pkg::TX_DELIM;
            end else if (tx_start && tx_len != 16'h0000) begin
               tx_status_next = 1'b0;
               tx_len_next    = tx_len;
               tx_cnt_next    = tx_len;
               tx_state_next  = codec_pkg::TX_DELIM;
            end
         end
         codec_pkg::TX_DELIM: begin
            load          = esc_slot;
            load_data     = `DELIM;
            tx_sum_next   = 8'h00;
            tx_state_next = esc_slot ? codec_pkg::TX_LEN_HI : tx_state_reg;
         end
         codec_pkg::TX_LEN_HI: begin
            load          = esc_slot;
            load_data     = tx_len_reg[15:8];
            tx_state_next = esc_slot ? codec_pkg::TX_LEN_LO : tx_state_reg;
         end
         codec_pkg::TX_LEN_LO: begin
            load      = esc_slot;
            load_data = tx_len_reg[7:0];
            if (esc_slot) begin
               tx_state_next = tx_status_reg ? codec_pkg::TX_STAT_TYPE : codec_pkg::TX_DATA;
            end
         end
         codec_pkg::TX_STAT_TYPE: begin
            load          = esc_slot;
            load_data     = `STATUS_FRAME_TYPE;
            tx_sum_next   = esc_slot ? tx_sum_reg + load_data : tx_sum_reg;
            tx_state_next = esc_slot ? codec_pkg::TX_STAT_CODE : tx_state_reg;
         end
         codec_pkg::TX_STAT_CODE: begin
            load          = esc_slot;
            load_data     = tx_code_reg;
            tx_sum_next   = esc_slot ? tx_sum_reg + load_data : tx_sum_reg;
            tx_state_next = esc_slot ? codec_pkg::TX_CKSUM : tx_state_reg;
         end
         codec_pkg::TX_DATA: begin
            load      = tx_take;
            load_data = tx_data;
            if (tx_take) begin
               tx_sum_next = tx_sum_reg + tx_data;
               tx_cnt_next = tx_cnt_reg - 16'h0001;
               if (tx_cnt_reg == 16'h0001) begin
                  tx_state_next = codec_pkg::TX_CKSUM;
               end
            end
         end
         codec_pkg::TX_CKSUM: begin
            load          = esc_slot;
            load_data     = `CKSUM_GOOD - tx_sum_reg;
            tx_state_next = esc_slot ? codec_pkg::TX_IDLE : tx_state_reg;
         end
      endcase
   end

   assign esc_in_valid_next = load || (esc_in_valid_reg && !esc_in_ready);
   assign esc_in_data_next  = load ? load_data : esc_in_data_reg;
   // Delimiter is never escaped; everything after it is in escaped mode
   assign esc_in_esc_next   = load ? (esc_mode && tx_state_reg != codec_pkg::TX_DELIM) : esc_in_esc_reg;
   // Ready only while the escaper input slot is empty, costing a cycle per byte
   assign tx_ready_next = tx_state_next == codec_pkg::TX_DATA && !esc_in_valid_next;

   always_ff @(posedge clk) begin
      if (reset) begin
         rx_state_reg    <= codec_pkg::RX_HUNT;
         rx_len_hi_reg   <= 8'h00;
         rx_cnt_reg      <= 16'h0000;
         rx_sum_reg      <= 8'h00;
         rx_esc_pend_reg <= 1'b0;
         good_reg        <= 1'b0;
         bad_reg         <= 1'b0;
         err_code_reg    <= 8'h00;
         err_pend_reg    <= 1'b0;
      end else begin
         rx_state_reg    <= rx_state_next;
         rx_len_hi_reg   <= rx_len_hi_next;
         rx_cnt_reg      <= rx_cnt_next;
         rx_sum_reg      <= rx_sum_next;
         rx_esc_pend_reg <= rx_esc_pend_next;
         good_reg        <= good_next;
         bad_reg         <= bad_next;
         err_code_reg    <= err_code_next;
         err_pend_reg    <= err_pend_next;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         tx_state_reg     <= codec_pkg::TX_IDLE;
         tx_len_reg       <= 16'h0000;
         tx_cnt_reg       <= 16'h0000;
         tx_sum_reg       <= 8'h00;
         tx_status_reg    <= 1'b0;
         tx_code_reg      <= 8'h00;
         tx_ready_reg     <= 1'b0;
         tx_busy_reg      <= 1'b0;
         esc_in_data_reg  <= 8'h00;
         esc_in_valid_reg <= 1'b0;
         esc_in_esc_reg   <= 1'b0;
      end else begin
         tx_state_reg     <= tx_state_next;
         tx_len_reg       <= tx_len_next;
         tx_cnt_reg       <= tx_cnt_next;
         tx_sum_reg       <= tx_sum_next;
         tx_status_reg    <= tx_status_next;
         tx_code_reg      <= tx_code_next;
         tx_ready_reg     <= tx_ready_next;
         tx_busy_reg      <= tx_state_next != codec_pkg::TX_IDLE;
         esc_in_data_reg  <= esc_in_data_next;
         esc_in_valid_reg <= esc_in_valid_next;
         esc_in_esc_reg   <= esc_in_esc_next;
      end
   end

   assign frame_good = good_reg;
   assign frame_bad  = bad_reg;
   assign err_code   = err_code_reg;
   assign tx_ready   = tx_ready_reg;
   assign tx_busy    = tx_busy_reg;

   two_entry_buffer #(
      .WIDTH (9)
   ) u_rx_buffer (
      .clk       (clk),
      .reset     (reset),
      .in_data   ({rx_last_in, rx_d}),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .out_data  ({rx_last, rx_data}),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );

   frame_byte_escaper u_escaper (
      .clk       (clk),
      .reset     (reset),
      .in_data   (esc_in_data_reg),
      .in_escape (esc_in_esc_reg),
      .in_valid  (esc_in_valid_reg),
      .in_ready  (esc_in_ready),
      .out_data  (uart_tx_byte),
      .out_valid (uart_tx_valid),
      .out_ready (uart_tx_ready)
   );

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   sequence s_tx_esc_out;
      esc_mode && uart_tx_valid && uart_tx_ready && uart_tx_byte == `ESC;
   endsequence

   sequence s_sum_byte;
      rx_state_reg == codec_pkg::RX_CKSUM && rx_plain_byte;
   endsequence

   // Judged at the buffer input: a stalled consumer may still hold an earlier frame
   AST_HUNT_DROP: assert property (rx_state_reg == codec_pkg::RX_HUNT && uart_rx_valid && !raw_delim
      |-> !buf_in_valid ##1 rx_state_reg == codec_pkg::RX_HUNT) else $error("byte before delimiter not dropped");
   AST_LEN_MSB: assert property (rx_state_reg == codec_pkg::RX_LEN_LO && rx_plain_byte && !len_bad
      |=> rx_cnt_reg == $past(rx_len_w) && rx_state_reg == codec_pkg::RX_DATA)
      else $error("length not assembled high byte first");
   AST_ESC_UNCOUNTED: assert property (rx_state_reg == codec_pkg::RX_DATA && rx_esc_byte
      |=> rx_cnt_reg == $past(rx_cnt_reg) && rx_sum_reg == $past(rx_sum_reg) && rx_esc_pend_reg)
      else $error("escape byte counted as data");
   AST_SUM_GOOD: assert property (s_sum_byte ##0 rx_sum_d == `CKSUM_GOOD
      |=> frame_good && !frame_bad ##1 !frame_good) else $error("good checksum not accepted");
   AST_SUM_BAD: assert property (s_sum_byte ##0 rx_sum_d != `CKSUM_GOOD
      |=> frame_bad && err_code == `ERR_CHECKSUM && rx_state_reg == codec_pkg::RX_HUNT)
      else $error("bad checksum not reported");
   AST_TX_ESCAPE: assert property (s_tx_esc_out
      |=> uart_tx_valid && codec_pkg::needs_escape(uart_tx_byte ^ `ESC_XOR))
      else $error("escape not followed by flipped special byte");
   AST_PLAIN_RAW: assert property (!esc_mode && esc_in_valid_reg && esc_in_ready
      |=> uart_tx_valid && uart_tx_byte == $past(esc_in_data_reg)) else $error("plain byte altered");
   AST_TX_CKSUM: assert property (tx_state_reg == codec_pkg::TX_CKSUM && esc_slot
      |=> esc_in_data_reg == `CKSUM_GOOD - $past(tx_sum_reg) && tx_state_reg == codec_pkg::TX_IDLE)
      else $error("sent checksum wrong");
   AST_TX_LEN_HI: assert property (tx_state_reg == codec_pkg::TX_LEN_HI && esc_slot
      |=> esc_in_data_reg == $past(tx_len_reg[15:8]) ##1 tx_state_reg != codec_pkg::TX_LEN_HI)
      else $error("length high byte not sent first");
   AST_STATUS_TYPE: assert property (tx_state_reg == codec_pkg::TX_STAT_TYPE && esc_slot
      |=> esc_in_data_reg == `STATUS_FRAME_TYPE) else $error("status frame type missing");
   AST_ERR_QUEUED: assert property (err_pend_reg && tx_state_reg == codec_pkg::TX_IDLE
      |=> tx_status_reg && tx_code_reg == $past(err_code_reg) && tx_state_reg == codec_pkg::TX_DELIM)
      else $error("error report lost");
endmodule

// file: test/host_uart_model.sv
// Host side of the serial link: sends raw bytes, records what the codec sends
// Assumes the bench calls send() and drives slow; one clock, reset high
`timescale 1ns/1ns
module host_uart_model (
   input  wire logic       clk,
   input  wire logic       reset,
   input  wire logic       slow,
   output logic      [7:0] uart_rx_byte,
   output logic            uart_rx_valid,
   input  wire logic [7:0] uart_tx_byte,
   input  wire logic       uart_tx_valid,
   output logic            uart_tx_ready
);
   logic [7:0] got[$];
   int         pos = 0;
   int         unknown_types = 0;

   initial begin
      uart_rx_byte = 8'h00;
      uart_rx_valid = 1'b0;
      uart_tx_ready = 1'b0;
   end

   // Slow host accepts only every other cycle
   always @(negedge clk) begin
      uart_tx_ready <= reset ? 1'b0 : (slow ? ~uart_tx_ready : 1'b1);
   end

   // Raw wire bytes are kept; the bench judges framing and escapes
   // Host knows only the status frame type; any other type is kept but counted in unknown_types
   always @(posedge clk) begin
      if (uart_tx_valid === 1'b1 && uart_tx_ready) begin
         got.push_back(uart_tx_byte);
         pos = (uart_tx_byte == 8'h7E) ? 1 : pos + 1;
         if (pos == 4 && uart_tx_byte != 8'h8A) unknown_types++;
      end
   end

   // Bytes go out already escaped by the caller; lane inverts when idle
   task automatic send(input logic [7:0] b);
      @(negedge clk);
      uart_rx_byte = b;
      uart_rx_valid = 1'b1;
      @(negedge clk);
      uart_rx_valid = 1'b0;
      uart_rx_byte = ~b;
   endtask
endmodule

// file: test/uart_api_frame_codec_bench.sv
// Self-checking bench for the frame codec with a host model on the link
// Assumes 10 MHz clock, inputs changed at the falling edge
`timescale 1ns/1ns
module uart_api_frame_codec_bench;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        rx_ready = 1'b1;
   logic        tx_start = 1'b0;
   logic        tx_valid = 1'b0;
   logic        slow = 1'b0;
   logic [1:0]  mode = 2'h1;
   logic [15:0] tx_len = 16'h0000;
   logic [7:0]  tx_data = 8'h00;
   logic [7:0]  rx_byte, tx_byte, rx_data, err_code;
   logic        rx_v, tx_v, tx_r, rx_last, rx_valid, frame_good, frame_bad, tx_ready, tx_busy;
   int          err_count = 0;
   int          tests_run = 0;
   int          goods, bads;
   logic [8:0]  rxq[$];

   always #50 clk = ~clk;

   host_uart_model host (.clk(clk), .reset(reset), .slow(slow), .uart_rx_byte(rx_byte),
      .uart_rx_valid(rx_v), .uart_tx_byte(tx_byte), .uart_tx_valid(tx_v), .uart_tx_ready(tx_r));

   uart_api_frame_codec dut (.clk(clk), .reset(reset), .framing_mode_select(mode),
      .uart_rx_byte(rx_byte), .uart_rx_valid(rx_v), .uart_tx_byte(tx_byte), .uart_tx_valid(tx_v),
      .uart_tx_ready(tx_r), .rx_data(rx_data), .rx_last(rx_last), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .frame_good(frame_good), .frame_bad(frame_bad), .err_code(err_code),
      .tx_start(tx_start), .tx_len(tx_len), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_busy(tx_busy));

   always @(posedge clk) begin
      if (rx_valid === 1'b1 && rx_ready) rxq.push_back({rx_last, rx_data});
      if (frame_good === 1'b1) goods++;
      if (frame_bad === 1'b1) bads++;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // Receive a raw byte stream; stall the consumer only when two or fewer entries are expected
   task automatic rx_frame(input logic [1:0] m, input logic [7:0] s[$], input logic [8:0] exp[$],
                           input int g, input int b);
      mode = m;
      rxq = {};
      goods = 0;
      bads = 0;
      rx_ready = exp.size() > 2;
      foreach (s[i]) host.send(s[i]);
      rx_ready = 1'b1;
      repeat (6) @(negedge clk);
      check(16'(rxq.size()), 16'(exp.size()));
      foreach (exp[i]) if (i < rxq.size()) check(16'(rxq[i]), 16'(exp[i]));
      check(16'(goods), 16'(g));
      check(16'(bads), 16'(b));
      $display("rx frame test done, mismatches %0d", err_count);
   endtask

   task automatic wait_tx(input logic [7:0] exp[$]);
      int k;
      k = 0;
      while (host.got.size() < exp.size() && k < 400) begin
         @(negedge clk);
         k++;
      end
      if (k == 400) begin
         err_count++;
         $display("FAIL %0t no frame on the link", $time);
         test_done();
      end
      foreach (exp[i]) check(16'(host.got[i]), 16'(exp[i]));
      host.got = {};
   endtask

   task automatic tx_frame(input logic [7:0] pay[$], input logic [7:0] exp[$]);
      int k;
      host.got = {};
      tx_len = 16'(pay.size());
      tx_start = 1'b1;
      @(negedge clk);
      tx_start = 1'b0;
      foreach (pay[i]) begin
         tx_data = pay[i];
         tx_valid = 1'b1;
         k = 0;
         while (tx_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
         end
         if (k == 100) begin
            err_count++;
            $display("FAIL %0t payload byte not taken", $time);
            test_done();
         end
         @(negedge clk);
      end
      tx_valid = 1'b0;
      wait_tx(exp);
      $display("tx frame test done, mismatches %0d", err_count);
   endtask

   initial begin
      repeat (8) @(negedge clk);
      reset = 1'b0;
      rx_frame(2'h1, '{8'h55, 8'h7D, 8'h7E, 8'h00, 8'h02, 8'h23, 8'h11, 8'hCB}, '{9'h023, 9'h111}, 1, 0);
      rx_frame(2'h2, '{8'h7E, 8'h00, 8'h02, 8'h7D, 8'h5E, 8'h7D, 8'h31, 8'h70}, '{9'h07E, 9'h111}, 1, 0);
      rx_frame(2'h1, '{8'h7E, 8'h00, 8'h02, 8'h23, 8'h11, 8'h00}, '{9'h023, 9'h111}, 0, 1);
      check(16'(err_code), 16'h0002);
      wait_tx('{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h02, 8'h73});
      rx_frame(2'h1, '{8'h7E, 8'h00, 8'h03, 8'h23, 8'h11, 8'h22, 8'h00}, '{9'h023, 9'h011}, 0, 1);
      check(16'(err_code), 16'h0003);
      wait_tx('{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h03, 8'h72});
      rx_frame(2'h2, '{8'h7E, 8'h00, 8'h02, 8'h23, 8'h7E, 8'h00, 8'h02, 8'h23, 8'h7D, 8'h31, 8'hCB},
               '{9'h023, 9'h023, 9'h111}, 1, 1);
      check(16'(err_code), 16'h0001);
      wait_tx('{8'h7E, 8'h00, 8'h02, 8'h8A, 8'h01, 8'h74});
      slow = 1'b1;
      tx_frame('{8'h23, 8'h11}, '{8'h7E, 8'h00, 8'h02, 8'h23, 8'h7D, 8'h31, 8'hCB});
      mode = 2'h1;
      tx_frame('{8'h11, 8'h13}, '{8'h7E, 8'h00, 8'h02, 8'h11, 8'h13, 8'hDB});
      check(16'(tx_busy), 16'h0000);
      check(16'(host.unknown_types), 16'h0002);
      test_done();
   end
endmodule
